// ===== tlec_params.svh
// constants for the two-level event controller: offsets, resets, counts
// assumes inclusion by the controller package and modules only
`ifndef TLEC_PARAMS_SVH
`define TLEC_PARAMS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define TLEC_CORE_LEVELS      16
`define TLEC_SRC_NUM          64
`define TLEC_GP_FIRST         7
`define TLEC_GP_NUM           9
`define TLEC_ASSIGN_NUM       8
`define TLEC_ASSIGN_FLD_W     4
`define TLEC_DETECT_CYCLES    2
`define TLEC_PEND_MIN_CYCLES  3

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define TLEC_OFS_LATCH        8'h00
`define TLEC_OFS_MASK         8'h04
`define TLEC_OFS_PENDING      8'h08
`define TLEC_OFS_PMASK0       8'h10
`define TLEC_OFS_PMASK1       8'h14
`define TLEC_OFS_PSTAT0       8'h18
`define TLEC_OFS_PSTAT1       8'h1C
`define TLEC_OFS_PWAKE0       8'h20
`define TLEC_OFS_PWAKE1       8'h24
`define TLEC_OFS_ASSIGN0      8'h40
`define TLEC_OFS_ASSIGN_LAST  8'h5C

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TLEC_RST_CORE16       16'h0000
`define TLEC_RST_WORD         32'h0000_0000
`define TLEC_RST_ASSIGN_SIXTH   32'h0666_6000
`define TLEC_RST_ASSIGN_SEVENTH 32'h3333_3003
`define TLEC_SYS_LEVEL_MASK   16'h007F

`endif

// ===== tlec_pkg.sv
// types shared by the two-level event controller modules
// assumes tlec_params.svh sits in the include path
`include "tlec_params.svh"

package tlec_pkg;
  typedef logic [3:0]  tlec_level_t;
  typedef logic [15:0] tlec_core_vec_t;
  typedef logic [31:0] tlec_word_t;
endpackage

// ===== tlec_edge_latch.sv
// per-level rising edge detector and event latch with masked writes
// assumes event inputs already synchronous to clk
`timescale 1ns/1ps

module tlec_edge_latch
  import tlec_pkg::*;
#(
  parameter int N = 16
)(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] ev_in,
  input  wire logic         sw_wr,
  input  wire logic [N-1:0] sw_data,
  input  wire logic [N-1:0] sw_allow,
  input  wire logic [N-1:0] take_clr,
  output logic      [N-1:0] latch
);
  logic [N-1:0] prev;
  logic [N-1:0] rise;
  logic [N-1:0] next_prev;
  logic [N-1:0] next_rise;
  logic [N-1:0] next_latch;

  // ----------------------------------------------------------------
  // edge detect over two cycles, then latch
  // ----------------------------------------------------------------
  always_comb
  begin
    next_prev  = ev_in;
    next_rise  = ev_in & ~prev;
    next_latch = latch & ~take_clr;
    // software reaches only bits whose mask is clear
    if (sw_wr)
    begin
      next_latch = (next_latch & ~sw_allow) | (sw_data & sw_allow);
    end
    // a fresh edge wins over acceptance and writes: next event queued
    next_latch = next_latch | rise;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prev  <= '0;
      rise  <= '0;
      latch <= '0;
    end
    else
    begin
      prev  <= next_prev;
      rise  <= next_rise;
      latch <= next_latch;
    end
  end

endmodule

// ===== tlec_prio_enc.sv
// lowest-set-bit finder used for service priority and nesting depth
// assumes N is at most 16
`timescale 1ns/1ps

module tlec_prio_enc
  import tlec_pkg::*;
#(
  parameter int N = 16
)(
  input  wire logic [N-1:0] req,
  output logic              any,
  output tlec_level_t       idx
);
  // ----------------------------------------------------------------
  // scan from the top so the lowest index is left standing
  // ----------------------------------------------------------------
  always_comb
  begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = tlec_level_t'(i);
      end
    end
  end

endmodule

// ===== tlec_top.sv
// two-level event controller: peripheral stage feeding core event stage
// assumes inputs synchronous to clk, priv high in supervisor/emulation
//
// What this block does
// - core latch, mask, pending registers, 16 bits
// - latch sets on capture, clears on acceptance
// - latch write acts only where mask clear
// - mask one lets event be serviced
// - mask zero withholds service, keeps latch
// - core mask read/write in supervisor mode
// - global gate over general-purpose levels
// - pending marks active or nested levels
// - three pairs of 32-bit peripheral registers
// - peripheral mask one forwards, zero blocks
// - registers reachable only when privileged
// - reset level map for ids 43-55
// - ids 43-47 sixth, 48-55 seventh assign
// - ids 43-63 in second pair register
// - latch on rising edge, two-cycle detect
// - pending no sooner than three cycles
// - status bit mirrors peripheral request level
// - wakeup enable lets event wake core
`timescale 1ns/1ps
`include "tlec_params.svh"

module tlec_top
  import tlec_pkg::*;
#(
  parameter int SRC_NUM = `TLEC_SRC_NUM
)(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [SRC_NUM-1:0] periph_req,
  input  wire logic [6:0]         sys_event,
  input  wire logic               sti_pulse,
  input  wire logic               cli_pulse,
  input  wire logic               svc_take,
  input  wire logic               svc_done,
  input  wire logic               priv,
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [31:0]        reg_wdata,
  output tlec_word_t              reg_rdata,
  output logic                    svc_req,
  output tlec_level_t             svc_level,
  output logic                    wake_req,
  output logic                    gie
);
  localparam int NL = `TLEC_CORE_LEVELS;
  localparam int NG = `TLEC_GP_NUM;
  localparam int NA = `TLEC_ASSIGN_NUM;
  localparam int FW = `TLEC_ASSIGN_FLD_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // core registers hold 16 bits; their upper read bits stay zero
  tlec_core_vec_t core_event_mask;
  tlec_core_vec_t core_event_pending;
  tlec_core_vec_t core_event_latch;
  tlec_word_t     peripheral_event_mask   [2];
  tlec_word_t     peripheral_event_status [2];
  tlec_word_t     peripheral_wakeup_enable[2];
  tlec_word_t     level_assign            [NA];

  tlec_core_vec_t next_core_event_mask;
  tlec_core_vec_t next_core_event_pending;
  tlec_word_t     next_peripheral_event_mask   [2];
  tlec_word_t     next_peripheral_event_status [2];
  tlec_word_t     next_peripheral_wakeup_enable[2];
  tlec_word_t     next_level_assign            [NA];
  tlec_word_t     next_reg_rdata;
  logic           next_svc_req;
  tlec_level_t    next_svc_level;
  logic           next_wake_req;
  logic           next_gie;

  logic           acc_wr;
  logic           acc_rd;
  logic [SRC_NUM-1:0] src_mask;
  logic [SRC_NUM-1:0] src_wake;
  logic [NG-1:0]  gp_req;
  tlec_core_vec_t ev_vec;
  tlec_core_vec_t take_clr;
  tlec_core_vec_t eligible;
  logic           cand_any;
  tlec_level_t    cand_lvl;
  logic           pend_any;
  tlec_level_t    pend_lvl;
  logic           latch_wr;

  // ----------------------------------------------------------------
  // access qualification
  // ----------------------------------------------------------------
  // unprivileged accesses see reserved space: writes dropped, reads zero
  assign acc_wr   = reg_wr & priv;
  assign acc_rd   = reg_rd & priv;
  assign latch_wr = acc_wr && (reg_addr == `TLEC_OFS_LATCH);
  assign src_mask = {peripheral_event_mask[1], peripheral_event_mask[0]};
  assign src_wake = {peripheral_wakeup_enable[1],
                     peripheral_wakeup_enable[0]};

  // ----------------------------------------------------------------
  // peripheral stage: per level OR of unmasked assigned sources
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NG; g++)
  begin : g_level
    logic [SRC_NUM-1:0] hit;
    for (genvar s = 0; s < SRC_NUM; s++)
    begin : g_src
      // field holds the gp level index, 0 meaning the first gp level
      assign hit[s] = periph_req[s] & src_mask[s]
        & (level_assign[s / 8][(s % 8) * FW +: FW] == FW'(g));
    end
    assign gp_req[g] = |hit;
  end

  assign ev_vec = {gp_req, sys_event};

  // ----------------------------------------------------------------
  // core stage
  // ----------------------------------------------------------------
  // acceptance empties the latch bit on the edge that sets pending
  assign take_clr = (svc_take && svc_req) ? (16'h0001 << svc_level)
                                          : `TLEC_RST_CORE16;

  tlec_edge_latch #(
    .N        (NL)
  ) u_latch (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ev_in    (ev_vec),
    .sw_wr    (latch_wr),
    .sw_data  (reg_wdata[15:0]),
    .sw_allow (~core_event_mask),
    .take_clr (take_clr),
    .latch    (core_event_latch)
  );

  // masked bits stay latched but never become candidates
  // gp levels also need the global gate; system levels bypass it
  assign eligible = core_event_latch & core_event_mask
    & (NL'({NG{gie}}) << `TLEC_GP_FIRST | `TLEC_SYS_LEVEL_MASK);

  tlec_prio_enc #(
    .N   (NL)
  ) u_cand (
    .req (eligible),
    .any (cand_any),
    .idx (cand_lvl)
  );

  tlec_prio_enc #(
    .N   (NL)
  ) u_pend (
    .req (core_event_pending),
    .any (pend_any),
    .idx (pend_lvl)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_core_event_mask = core_event_mask;
    next_core_event_pending = core_event_pending;
    next_peripheral_event_mask = peripheral_event_mask;
    next_peripheral_wakeup_enable = peripheral_wakeup_enable;
    next_level_assign = level_assign;
    next_gie = gie;
    next_reg_rdata = `TLEC_RST_WORD;

    // status mirrors the live request level, no stickiness
    next_peripheral_event_status[0] = periph_req[31:0];
    next_peripheral_event_status[1] = periph_req[63:32];

    // disable wins when both instructions land together
    if (sti_pulse)
    begin
      next_gie = 1'b1;
    end
    if (cli_pulse)
    begin
      next_gie = 1'b0;
    end

    // only a level above the current nesting depth may interrupt
    next_svc_req   = cand_any &&
                     (!pend_any || cand_lvl < pend_lvl);
    next_svc_level = cand_lvl;
    if (svc_take && svc_req)
    begin
      next_svc_req = 1'b0;
    end

    // return retires the innermost level; entry sets the new one
    if (svc_done && pend_any)
    begin
      next_core_event_pending[pend_lvl] = 1'b0;
    end
    if (svc_take && svc_req)
    begin
      next_core_event_pending[svc_level] = 1'b1;
    end

    next_wake_req = |(periph_req & src_wake);

    if (acc_wr)
    begin
      unique case (reg_addr)
        `TLEC_OFS_MASK:   next_core_event_mask = reg_wdata[15:0];
        `TLEC_OFS_PMASK0:
        begin
          next_peripheral_event_mask[0] = reg_wdata;
        end
        `TLEC_OFS_PMASK1:
        begin
          next_peripheral_event_mask[1] = reg_wdata;
        end
        `TLEC_OFS_PWAKE0: next_peripheral_wakeup_enable[0] = reg_wdata;
        `TLEC_OFS_PWAKE1: next_peripheral_wakeup_enable[1] = reg_wdata;
        default:
        begin
          if (reg_addr >= `TLEC_OFS_ASSIGN0 &&
              reg_addr <= `TLEC_OFS_ASSIGN_LAST && reg_addr[1:0] == 2'b00)
          begin
            next_level_assign[reg_addr[4:2]] = reg_wdata;
          end
        end
      endcase
    end

    if (acc_rd)
    begin
      unique case (reg_addr)
        `TLEC_OFS_LATCH:   next_reg_rdata = {16'h0000, core_event_latch};
        `TLEC_OFS_MASK:    next_reg_rdata = {16'h0000, core_event_mask};
        `TLEC_OFS_PENDING: next_reg_rdata = {16'h0000, core_event_pending};
        `TLEC_OFS_PMASK0:  next_reg_rdata = peripheral_event_mask[0];
        `TLEC_OFS_PMASK1:  next_reg_rdata = peripheral_event_mask[1];
        `TLEC_OFS_PSTAT0:  next_reg_rdata = peripheral_event_status[0];
        `TLEC_OFS_PSTAT1:  next_reg_rdata = peripheral_event_status[1];
        `TLEC_OFS_PWAKE0:  next_reg_rdata = peripheral_wakeup_enable[0];
        `TLEC_OFS_PWAKE1:  next_reg_rdata = peripheral_wakeup_enable[1];
        default:
        begin
          if (reg_addr >= `TLEC_OFS_ASSIGN0 &&
              reg_addr <= `TLEC_OFS_ASSIGN_LAST && reg_addr[1:0] == 2'b00)
          begin
            next_reg_rdata = level_assign[reg_addr[4:2]];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_event_mask    <= `TLEC_RST_CORE16;
      core_event_pending <= `TLEC_RST_CORE16;
      for (int i = 0; i < 2; i++)
      begin
        peripheral_event_mask[i]    <= `TLEC_RST_WORD;
        peripheral_event_status[i]  <= `TLEC_RST_WORD;
        peripheral_wakeup_enable[i] <= `TLEC_RST_WORD;
      end
      for (int i = 0; i < NA; i++)
      begin
        level_assign[i] <= `TLEC_RST_WORD;
      end
      level_assign[5] <= `TLEC_RST_ASSIGN_SIXTH;
      level_assign[6] <= `TLEC_RST_ASSIGN_SEVENTH;
      reg_rdata <= `TLEC_RST_WORD;
      svc_req   <= 1'b0;
      svc_level <= '0;
      wake_req  <= 1'b0;
      gie       <= 1'b0;
    end
    else
    begin
      core_event_mask          <= next_core_event_mask;
      core_event_pending       <= next_core_event_pending;
      peripheral_event_mask    <= next_peripheral_event_mask;
      peripheral_event_status  <= next_peripheral_event_status;
      peripheral_wakeup_enable <= next_peripheral_wakeup_enable;
      level_assign             <= next_level_assign;
      reg_rdata <= next_reg_rdata;
      svc_req   <= next_svc_req;
      svc_level <= next_svc_level;
      wake_req  <= next_wake_req;
      gie       <= next_gie;
    end
  end

endmodule

// ===== tlec_chk_assertions.sv
// port checker for the two-level event controller
// assumes one clk domain with sys_rst synchronous, active high
`timescale 1ns/1ps

module tlec_chk
  import tlec_pkg::*;
#(
  parameter int SRC_NUM = 64
)(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic [SRC_NUM-1:0] periph_req,
  input wire logic               sti_pulse,
  input wire logic               cli_pulse,
  input wire logic               svc_take,
  input wire logic               priv,
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_rd,
  input wire tlec_word_t         reg_rdata,
  input wire logic               svc_req,
  input wire tlec_level_t        svc_level,
  input wire logic               wake_req,
  input wire logic               gie
);
  // ----------
  // properties
  // ----------
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_rdata_idle_zero:
    assert property (!(reg_rd && priv) |=> reg_rdata == 32'h0)
    else $error("read data without privileged read");
  a_core_upper_zero:
    assert property (reg_rd && priv && reg_addr <= 8'h08
      |=> reg_rdata[31:16] == 16'h0) else $error("core word too wide");
  a_cli_closes_gate:
    assert property (cli_pulse |=> !gie)
    else $error("gate open after close pulse");
  a_sti_opens_gate:
    assert property (sti_pulse && !cli_pulse |=> gie)
    else $error("gate shut after open pulse");
  a_gate_holds_still:
    assert property (!sti_pulse && !cli_pulse |=> $stable(gie))
    else $error("gate moved without a pulse");
  a_gate_blocks_gp:
    assert property (!gie && !$past(gie) |-> !(svc_req && svc_level >= 4'h7))
    else $error("general level offered with gate shut");
  a_take_drops_offer:
    assert property (svc_take && svc_req |=> !svc_req)
    else $error("offer stands after take");
  a_wake_has_cause:
    assert property (wake_req |-> $past(|periph_req))
    else $error("wake without a peripheral request");
endmodule

bind tlec_top tlec_chk #(.SRC_NUM(SRC_NUM)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .periph_req(periph_req),
  .sti_pulse(sti_pulse), .cli_pulse(cli_pulse), .svc_take(svc_take),
  .priv(priv), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .svc_req(svc_req), .svc_level(svc_level),
  .wake_req(wake_req), .gie(gie)
);

// ===== tlec_core_model.sv
// core pipeline model answering service offers of the controller
// assumes clk from the bench; drives only at the falling edge
`timescale 1ns/1ps

module tlec_core_model #(
  parameter int SVC_CYC = 12
)(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic take_en,
  input  wire logic svc_req,
  output logic      svc_take,
  output logic      svc_done
);
  int   depth;
  int   timer;
  logic take_ok;

  initial
  begin
    svc_take = 1'b0;
    svc_done = 1'b0;
  end

  // enable taken on the rising edge, away from the bench's falling drive
  always @(posedge clk)
  begin
    take_ok <= take_en;
  end

  // ----------
  // handler
  // ----------
  // fixed handler length; a nested take restarts it, so done is innermost
  always @(negedge clk)
  begin
    svc_take = 1'b0;
    svc_done = 1'b0;
    if (sys_rst)
    begin
      depth = 0;
      timer = 0;
    end
    else if (take_ok && svc_req)
    begin
      svc_take = 1'b1;
      depth++;
      timer = 0;
    end
    else if (depth > 0)
    begin
      timer++;
      if (timer == SVC_CYC)
      begin
        svc_done = 1'b1;
        depth--;
        timer = 0;
      end
    end
  end
endmodule

// ===== tb_top.sv
// self-checking bench for tlec_top with a core model partner
// assumes design files and tlec_core_model compiled before it
`timescale 1ns/1ps

module tb_top
  import tlec_pkg::*;
  ;
  logic        clk;
  logic        sys_rst;
  logic [63:0] periph_req;
  logic [6:0]  sys_event;
  logic        sti_pulse;
  logic        cli_pulse;
  logic        svc_take;
  logic        svc_done;
  logic        priv;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  tlec_word_t  reg_wdata;
  tlec_word_t  reg_rdata;
  logic        svc_req;
  tlec_level_t svc_level;
  logic        wake_req;
  logic        gie;
  logic        take_en;
  tlec_level_t taken[$];
  int          fail_count;
  int          comparisons;
  int          cyc;

  tlec_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .periph_req(periph_req),
    .sys_event(sys_event), .sti_pulse(sti_pulse), .cli_pulse(cli_pulse),
    .svc_take(svc_take), .svc_done(svc_done), .priv(priv),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .svc_req(svc_req),
    .svc_level(svc_level), .wake_req(wake_req), .gie(gie)
  );
  tlec_core_model i_core (
    .clk(clk), .sys_rst(sys_rst), .take_en(take_en),
    .svc_req(svc_req), .svc_take(svc_take), .svc_done(svc_done)
  );

  // ----------
  // clock, log, timeout
  // ----------
  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    if (svc_take && svc_req)
      taken.push_back(svc_level);
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input tlec_word_t got, input tlec_word_t exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input tlec_word_t d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // read data stands one cycle after the strobe edge
  task automatic rchk(input logic [7:0] a, input tlec_word_t exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask

  task automatic gate(input logic open);
    @(negedge clk);
    sti_pulse = open;
    cli_pulse = !open;
    @(negedge clk);
    sti_pulse = 1'b0;
    cli_pulse = 1'b0;
  endtask

  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ----------
  // tests
  // ----------
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    periph_req = '0;
    sys_event = 7'h0;
    sti_pulse = 1'b0;
    cli_pulse = 1'b0;
    priv = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
    take_en = 1'b0;
    waitn(20);
    sys_rst = 1'b0;
    rchk(8'h54, 32'h0666_6000);
    rchk(8'h58, 32'h3333_3003);
    rchk(8'h14, 32'h0);
    rchk(8'h40, 32'h0);
    $display("test reset done");
    wr(8'h04, 32'hFFFF_FFFF);
    rchk(8'h04, 32'h0000_FFFF);
    wr(8'h04, 32'h0000_00F0);
    wr(8'h00, 32'h0000_00FF);
    rchk(8'h00, 32'h0000_000F);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'hA5A5_5A5A);
    rchk(8'h14, 32'hA5A5_5A5A);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h5A5A_A5A5);
    rchk(8'h10, 32'h5A5A_A5A5);
    wr(8'h10, 32'h0);
    wr(8'h20, 32'h0000_0003);
    rchk(8'h20, 32'h0000_0003);
    wr(8'h20, 32'h0);
    rchk(8'h18, 32'h0);
    wr(8'h08, 32'h0000_FFFF);
    rchk(8'h08, 32'h0);
    priv = 1'b0;
    wr(8'h04, 32'h0000_1234);
    rchk(8'h04, 32'h0);
    priv = 1'b1;
    rchk(8'h04, 32'h0000_00F0);
    rchk(8'h30, 32'h0);
    $display("test registers done");
    wr(8'h04, 32'h0);
    sys_event[2] = 1'b1;
    waitn(4);
    chk(32'(svc_req), 32'h0);
    rchk(8'h00, 32'h0000_0004);
    wr(8'h04, 32'h0000_0002);
    sys_event[1] = 1'b1;
    waitn(2);
    chk(32'(svc_req), 32'h0);
    waitn(1);
    chk(32'({svc_req, svc_level}), 32'h11);
    take_en = 1'b1;
    waitn(2);
    rchk(8'h08, 32'h0000_0002);
    rchk(8'h00, 32'h0000_0004);
    waitn(16);
    rchk(8'h08, 32'h0);
    sys_event = 7'h0;
    take_en = 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0000_0038);
    sys_event = 7'h28;
    waitn(4);
    chk(32'({svc_req, svc_level}), 32'h13);
    taken.delete();
    take_en = 1'b1;
    for (int i = 0; i < 60 && taken.size() < 2; i++)
      @(negedge clk);
    chk(32'({taken[0], taken[1]}), 32'h35);
    sys_event[4] = 1'b1;
    waitn(4);
    rchk(8'h08, 32'h0000_0030);
    sys_event = 7'h0;
    waitn(40);
    $display("test priority done");
    gate(1'b1);
    chk(32'(gie), 32'h1);
    wr(8'h04, 32'h0000_2000);
    wr(8'h14, 32'h0000_1000);
    taken.delete();
    periph_req[45] = 1'b1;
    waitn(6);
    chk(32'(svc_req), 32'h0);
    rchk(8'h1C, 32'h0000_2000);
    periph_req[44] = 1'b1;
    waitn(6);
    chk(32'(taken[0]), 32'hD);
    wr(8'h24, 32'h0000_1000);
    waitn(2);
    chk(32'(wake_req), 32'h1);
    periph_req[44] = 1'b0;
    waitn(3);
    chk(32'(wake_req), 32'h0);
    gate(1'b0);
    chk(32'(gie), 32'h0);
    periph_req[44] = 1'b1;
    waitn(6);
    chk(32'(svc_req), 32'h0);
    rchk(8'h00, 32'h0000_2000);
    gate(1'b1);
    waitn(6);
    chk(32'(taken.size()), 32'h2);
    $display("test peripheral done");
    wr(8'h14, 32'h0001_0000);
    wr(8'h04, 32'h0000_0400);
    periph_req[48] = 1'b1;
    waitn(6);
    chk(32'(taken[2]), 32'hA);
    rchk(8'h1C, 32'h0001_3000);
    wr(8'h58, 32'h3333_3006);
    wr(8'h04, 32'h0000_2400);
    periph_req[48] = 1'b0;
    waitn(2);
    periph_req[48] = 1'b1;
    waitn(20);
    chk(32'(taken[3]), 32'hD);
    $display("test mapping done");
    complete_run();
  end
endmodule
